/* File: verilog/gp_timer_pkg.sv */
// Constants, types and helpers for the host timer and word mapping block.
// Behaviour
// - Bit 29 set runs timer, clear halts.
// - Run bit falling forces preload to FFFFh.
// - Preload in bits 15-0, resets FFFFh.
// - Timer raises interval events from preload.
// - Count register shows live 16-bit count.
// - Normal map: A[1] high selects upper half.
// - Swap pattern: A[1] high selects lower half.
// - Network side always low word first.
// - 32-bit counter, zero at reset, 25MHz.
// - Free counter wraps to zero, keeps counting.
// - First half read latches whole count.
// - Counter reads cleared within 160ns of reset.
// - Free counter never gated by power state.
package gp_timer_pkg;

	// Register byte offsets on the host bus.
	localparam logic [7:0] OFS_RX_DATA      = 8'h00;
	localparam logic [7:0] OFS_TX_DATA      = 8'h20;
	localparam logic [7:0] OFS_TIMER_CONFIG = 8'h8C;
	localparam logic [7:0] OFS_TIMER_COUNT  = 8'h90;
	localparam logic [7:0] OFS_WORD_ORDER   = 8'h98;
	localparam logic [7:0] OFS_FREE_TICK    = 8'h9C;

	// Field positions and reset values.
	localparam int          RUN_BIT          = 29;
	localparam int          HALF_W           = 16;
	localparam logic [15:0] PRELOAD_RESET    = 16'hFFFF;
	localparam logic [15:0] COUNT_RESET      = 16'hFFFF;
	localparam logic [15:0] HALF_ZERO        = 16'h0000;
	localparam logic [31:0] WORD_ORDER_RESET = 32'h0000_0000;
	localparam logic [31:0] SWAP_PATTERN     = 32'hFFFF_FFFF;
	localparam logic [31:0] FREE_RESET       = 32'h0000_0000;

	// The 25 MHz tick is made from 40 MHz by adding 5 per cycle modulo 8.
	localparam logic [3:0]  TICK_STEP        = 4'h5;
	localparam logic [2:0]  TICK_ACC_RESET   = 3'h0;

	// Host pins after synchronisation, all active high.
	typedef struct packed {
		logic        sel;
		logic        rd;
		logic        wr;
		logic [7:1]  addr;
		logic [15:0] data;
	} host_bus_s;

	// Transmit word serialiser states.
	typedef enum {TX_IDLE, TX_LOW, TX_HIGH} tx_state_e;

	// True when a host half-word address falls in the given register.
	function automatic logic word_hit(input logic [7:1] addr,
		input logic [7:0] ofs);
		word_hit = (addr[7:2] == ofs[7:2]);
	endfunction

	// Selects the register half that a host access reaches.
	function automatic logic half_is_high(input logic addr1,
		input logic swap);
		half_is_high = addr1 ^ swap;
	endfunction

	// Merges one host half-word into a 32-bit register image.
	function automatic logic [31:0] merge_half(input logic [31:0] old,
		input logic high, input logic [15:0] data);
		merge_half = high ? {data, old[15:0]} : {old[31:16], data};
	endfunction

	// Picks the half of a 32-bit image that a read returns.
	function automatic logic [15:0] pick_half(input logic [31:0] word,
		input logic high);
		pick_half = high ? word[31:16] : word[15:0];
	endfunction

endpackage

/* File: verilog/free_tick_counter.sv */
// Free-running 25 MHz tick counter with a read snapshot.
`timescale 1ns/100ps
module free_tick_counter
	import gp_timer_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Host read of the counter register started this cycle.
	input  wire logic        read_start,
	// Tick enable and snapshot.
	output logic             tick,
	output logic [31:0]      snap
);

	logic [2:0]  acc_q;
	logic [2:0]  acc_d;
	logic        tick_q;
	logic        tick_d;
	logic [31:0] count_q;
	logic [31:0] count_d;
	logic [31:0] snap_q;
	logic [31:0] snap_d;
	logic        held_q;
	logic        held_d;
	logic [3:0]  sum;

	// Fractional divider and counter; no power input can stop it.
	always_comb begin
		sum     = {1'b0, acc_q} + TICK_STEP;
		acc_d   = sum[2:0];
		tick_d  = sum[3];
		count_d = count_q;
		if (sum[3]) begin
			count_d = count_q + 32'h0000_0001;
		end
		snap_d = snap_q;
		held_d = held_q;
		// The first read of a pair samples all 32 bits; the second reuses it.
		if (read_start) begin
			held_d = ~held_q;
			if (!held_q) begin
				snap_d = count_q;
			end
		end
	end

	// Reset clears the count at once, well inside the settling window.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acc_q   <= TICK_ACC_RESET;
			tick_q  <= 1'b0;
			count_q <= FREE_RESET;
			snap_q  <= FREE_RESET;
			held_q  <= 1'b0;
		end else begin
			acc_q   <= acc_d;
			tick_q  <= tick_d;
			count_q <= count_d;
			snap_q  <= snap_d;
			held_q  <= held_d;
		end
	end

	assign tick = tick_q;
	assign snap = snap_q;

endmodule

/* File: verilog/gp_timer_freerun_wordswap.sv */
// Host register front end with timer, word order control and data ports.
`timescale 1ns/100ps
module gp_timer_freerun_wordswap
	import gp_timer_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Host bus pins.
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [7:1]  addr,
	input  wire logic [15:0] data_in,
	output logic [15:0]      data_out,
	output logic             data_oe,
	// Timer interval event.
	output logic             timer_wrap,
	// Network side transmit words.
	output logic [15:0]      net_tx_word,
	output logic             net_tx_valid,
	// Network side receive words.
	input  wire logic [15:0] net_rx_word,
	input  wire logic        net_rx_valid,
	output logic             rx_ready
);

	host_bus_s   pin_bus;
	host_bus_s   sync1_q;
	host_bus_s   sync2_q;
	logic        rd_prev_q;
	logic        wr_prev_q;
	logic [7:1]  wr_addr_q;
	logic [7:1]  wr_addr_d;
	logic [15:0] wr_data_q;
	logic [15:0] wr_data_d;
	logic        rd_act;
	logic        wr_act;
	logic        rd_start;
	logic        wr_done;
	logic        swap;
	logic        wr_high;
	logic        rd_high;

	logic        run_q;
	logic        run_d;
	logic [15:0] preload_q;
	logic [15:0] preload_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic        wrap_q;
	logic        wrap_d;
	logic [31:0] word_order_q;
	logic [31:0] word_order_d;
	logic [31:0] cfg_view;
	logic [31:0] cfg_new;

	tx_state_e   tx_state_q;
	tx_state_e   tx_state_d;
	logic [31:0] tx_hold_q;
	logic [31:0] tx_hold_d;
	logic [31:0] tx_entry_q;
	logic [31:0] tx_entry_d;
	logic [15:0] tx_word_q;
	logic [15:0] tx_word_d;
	logic        tx_valid_q;
	logic        tx_valid_d;
	logic        rx_half_q;
	logic        rx_half_d;
	logic [15:0] rx_low_q;
	logic [15:0] rx_low_d;
	logic [31:0] rx_entry_q;
	logic [31:0] rx_entry_d;
	logic        rx_ready_q;
	logic        rx_ready_d;

	logic [15:0] dout_q;
	logic [15:0] dout_d;
	logic        doe_q;
	logic        doe_d;
	logic [31:0] rd_word;

	logic        tick;
	logic [31:0] free_snap;

	// Pins arrive from another domain, so two flops precede any logic.
	assign pin_bus = '{sel: ~cs_n, rd: ~rd_n, wr: ~wr_n, addr: addr,
		data: data_in};

	assign rd_act   = sync2_q.sel & sync2_q.rd;
	assign wr_act   = sync2_q.sel & sync2_q.wr;
	assign rd_start = rd_act & ~rd_prev_q;
	assign wr_done  = wr_prev_q & ~wr_act;

	// The swap pattern must match exactly; any other value maps normally.
	assign swap    = (word_order_q == SWAP_PATTERN);
	assign wr_high = half_is_high(wr_addr_q[1], swap);
	assign rd_high = half_is_high(sync2_q.addr[1], swap);

	// Reserved bits of the configuration register always read as zero.
	assign cfg_view = {2'b00, run_q, 13'h0000, preload_q};

	// Write address and data are held from the active phase of the strobe.
	always_comb begin
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		if (wr_act) begin
			wr_addr_d = sync2_q.addr;
			wr_data_d = sync2_q.data;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= HALF_ZERO;
		end else begin
			sync1_q   <= pin_bus;
			sync2_q   <= sync1_q;
			rd_prev_q <= rd_act;
			wr_prev_q <= wr_act;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
		end
	end

	// Timer and writable registers; a write lands when the strobe ends.
	always_comb begin
		cfg_new      = merge_half(cfg_view, wr_high, wr_data_q);
		run_d        = run_q;
		preload_d    = preload_q;
		count_d      = count_q;
		wrap_d       = 1'b0;
		word_order_d = word_order_q;
		// Counting steps on the 25 MHz tick so intervals are predictable.
		if (run_q && tick) begin
			if (count_q == HALF_ZERO) begin
				count_d = preload_q;
				wrap_d  = 1'b1;
			end else begin
				count_d = count_q - 16'h0001;
			end
		end
		if (wr_done && word_hit(wr_addr_q, OFS_TIMER_CONFIG)) begin
			run_d     = cfg_new[RUN_BIT];
			preload_d = cfg_new[HALF_W-1:0];
			if (!run_q && cfg_new[RUN_BIT]) begin
				count_d = cfg_new[HALF_W-1:0];
			end
			if (run_q && !cfg_new[RUN_BIT]) begin
				preload_d = PRELOAD_RESET;
			end
		end
		if (wr_done && word_hit(wr_addr_q, OFS_WORD_ORDER)) begin
			word_order_d = merge_half(word_order_q, wr_high, wr_data_q);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			run_q        <= 1'b0;
			preload_q    <= PRELOAD_RESET;
			count_q      <= COUNT_RESET;
			wrap_q       <= 1'b0;
			word_order_q <= WORD_ORDER_RESET;
		end else begin
			run_q        <= run_d;
			preload_q    <= preload_d;
			count_q      <= count_d;
			wrap_q       <= wrap_d;
			word_order_q <= word_order_d;
		end
	end

	// Data ports: the host side follows the word order setting, while the
	// network side is fixed low word first in both directions.
	always_comb begin
		tx_hold_d  = tx_hold_q;
		tx_entry_d = tx_entry_q;
		tx_state_d = tx_state_q;
		tx_word_d  = tx_word_q;
		tx_valid_d = 1'b0;
		rx_half_d  = rx_half_q;
		rx_low_d   = rx_low_q;
		rx_entry_d = rx_entry_q;
		rx_ready_d = rx_ready_q;
		if (wr_done && word_hit(wr_addr_q, OFS_TX_DATA)) begin
			tx_hold_d = merge_half(tx_hold_q, wr_high, wr_data_q);
			// The A[1] high write closes an entry for the network.
			if (wr_addr_q[1]) begin
				tx_entry_d = tx_hold_d;
				tx_state_d = TX_LOW;
			end
		end
		case (tx_state_q)
			TX_IDLE: begin
				// Nothing to send until the next entry is closed.
			end
			TX_LOW: begin
				tx_word_d  = tx_entry_q[HALF_W-1:0];
				tx_valid_d = 1'b1;
				tx_state_d = TX_HIGH;
			end
			TX_HIGH: begin
				tx_word_d  = tx_entry_q[31:HALF_W];
				tx_valid_d = 1'b1;
				if (tx_state_d == TX_HIGH) begin
					tx_state_d = TX_IDLE;
				end
			end
			default: begin
				tx_state_d = TX_IDLE;
			end
		endcase
		// Reading the A[1] high half releases the receive entry.
		if (rd_start && word_hit(sync2_q.addr, OFS_RX_DATA)
			&& sync2_q.addr[1]) begin
			rx_ready_d = 1'b0;
		end
		// A completing word is applied last, so it beats the host release.
		if (net_rx_valid) begin
			if (!rx_half_q) begin
				rx_low_d  = net_rx_word;
				rx_half_d = 1'b1;
			end else begin
				rx_entry_d = {net_rx_word, rx_low_q};
				rx_ready_d = 1'b1;
				rx_half_d  = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_hold_q  <= 32'h0000_0000;
			tx_entry_q <= 32'h0000_0000;
			tx_state_q <= TX_IDLE;
			tx_word_q  <= HALF_ZERO;
			tx_valid_q <= 1'b0;
			rx_half_q  <= 1'b0;
			rx_low_q   <= HALF_ZERO;
			rx_entry_q <= 32'h0000_0000;
			rx_ready_q <= 1'b0;
		end else begin
			tx_hold_q  <= tx_hold_d;
			tx_entry_q <= tx_entry_d;
			tx_state_q <= tx_state_d;
			tx_word_q  <= tx_word_d;
			tx_valid_q <= tx_valid_d;
			rx_half_q  <= rx_half_d;
			rx_low_q   <= rx_low_d;
			rx_entry_q <= rx_entry_d;
			rx_ready_q <= rx_ready_d;
		end
	end

	// Read path; the bus drives while select and read were both low two edges earlier.
	always_comb begin
		rd_word = 32'h0000_0000;
		if (word_hit(sync2_q.addr, OFS_TIMER_CONFIG)) begin
			rd_word = cfg_view;
		end else if (word_hit(sync2_q.addr, OFS_TIMER_COUNT)) begin
			rd_word = {HALF_ZERO, count_q};
		end else if (word_hit(sync2_q.addr, OFS_WORD_ORDER)) begin
			rd_word = word_order_q;
		end else if (word_hit(sync2_q.addr, OFS_FREE_TICK)) begin
			rd_word = free_snap;
		end else if (word_hit(sync2_q.addr, OFS_RX_DATA)) begin
			rd_word = rx_entry_q;
		end
		dout_d = dout_q;
		doe_d  = rd_act;
		if (rd_act) begin
			dout_d = pick_half(rd_word, rd_high);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dout_q <= HALF_ZERO;
			doe_q  <= 1'b0;
		end else begin
			dout_q <= dout_d;
			doe_q  <= doe_d;
		end
	end

	// Free counter; the snapshot is taken on the first read of a pair.
	free_tick_counter i_free_tick_counter (
		.mclk       (mclk),
		.rstn       (rstn),
		.read_start (rd_start && word_hit(sync2_q.addr, OFS_FREE_TICK)),
		.tick       (tick),
		.snap       (free_snap)
	);

	// Every output comes straight from a register.
	assign data_out     = dout_q;
	assign data_oe      = doe_q;
	assign timer_wrap   = wrap_q;
	assign net_tx_word  = tx_word_q;
	assign net_tx_valid = tx_valid_q;
	assign rx_ready     = rx_ready_q;

endmodule

/* File: verif/gp_timer_checker.sv */
// Port checker for the host timer and word mapping block.
`timescale 1ns/100ps
module gp_timer_checker (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rstn,
	// Host bus.
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic data_oe,
	// Events and network side.
	input wire logic timer_wrap,
	input wire logic net_tx_valid,
	input wire logic net_rx_valid,
	input wire logic rx_ready
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// The timer leaves reset halted, so no interval event can come at once.
	a_wrap_quiet: assert property ($rose(rstn) |-> !timer_wrap[*8])
		else $error("Timer event soon after reset.");
	a_reset_idle: assert property ($rose(rstn) |-> !data_oe && !rx_ready)
		else $error("Bus or receive flag active after reset.");
	a_tx_pair: assert property (net_tx_valid && !$past(net_tx_valid)
		|=> net_tx_valid ##1 !net_tx_valid)
		else $error("Transmit entry not sent as two words.");
	a_tx_after_wr: assert property ($rose(net_tx_valid)
		|-> $past(wr_n) && $past(wr_n, 2))
		else $error("Transmit words before the write ended.");
	a_rx_after_valid: assert property ($rose(rx_ready)
		|-> $past(net_rx_valid))
		else $error("Receive entry without a received word.");
	// A read held four edges must be answered by then.
	a_oe_rise: assert property ((!cs_n && !rd_n)[*4] |-> data_oe)
		else $error("Read not answered in time.");
	a_oe_idle: assert property ((cs_n || rd_n)[*4] |-> !data_oe)
		else $error("Bus driven without a read.");
	a_oe_fall: assert property ($fell(data_oe)
		|-> $past(rd_n, 2) || $past(cs_n, 2))
		else $error("Bus released while read still held.");
endmodule

bind gp_timer_freerun_wordswap gp_timer_checker i_gp_timer_checker (
	.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
	.data_oe(data_oe), .timer_wrap(timer_wrap), .net_tx_valid(net_tx_valid),
	.net_rx_valid(net_rx_valid), .rx_ready(rx_ready));

/* File: verif/host_model.sv */
// Host processor model for the 16-bit asynchronous register bus.
`timescale 1ns/100ps
module host_model (
	// Clock.
	input wire logic        mclk,
	// Bus pins toward the block.
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic [7:1]      addr,
	output logic [15:0]     data_in,
	// Read data.
	input wire logic [15:0] data_out
);
	// Bus idles deselected.
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 7'h00;
		data_in = 16'h0000;
	end

	// Both strobe phases last four cycles, above the synchronisers' two.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1;
		addr = a[7:1];
		data_in = d;
		cs_n = 1'b0;
		wr_n = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		cs_n = 1'b1;
		wr_n = 1'b1;
		addr = ~addr; // Released lines must not keep their value.
		data_in = ~data_in;
		repeat (4) @(posedge mclk);
	endtask

	// Six edges cover the snapshot delay of the free count.
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		#1;
		addr = a[7:1];
		cs_n = 1'b0;
		rd_n = 1'b0;
		// Data is taken a step after an edge, where it has settled.
		repeat (5) @(posedge mclk);
		#1;
		d = data_out;
		@(posedge mclk);
		#1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		addr = ~addr;
		repeat (4) @(posedge mclk);
	endtask
endmodule

/* File: verif/gp_timer_freerun_wordswap_tb_top.sv */
// Self-checking testbench for the timer and word mapping block.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module gp_timer_freerun_wordswap_tb_top;
	logic        mclk, rstn, cs_n, rd_n, wr_n, data_oe, timer_wrap;
	logic        net_tx_valid, net_rx_valid, rx_ready;
	logic [7:1]  addr;
	logic [15:0] data_in, data_out, net_tx_word, net_rx_word;
	logic [15:0] txq[$];
	int          mismatches = 0;
	int          compares = 0;

	gp_timer_freerun_wordswap i_gp_timer_freerun_wordswap (.mclk(mclk),
		.rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.timer_wrap(timer_wrap), .net_tx_word(net_tx_word),
		.net_tx_valid(net_tx_valid), .net_rx_word(net_rx_word),
		.net_rx_valid(net_rx_valid), .rx_ready(rx_ready));
	host_model host (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.addr(addr), .data_in(data_in), .data_out(data_out));

	// Clock and transmit word capture.
	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;
	always @(negedge mclk) begin
		if (net_tx_valid === 1'b1) begin
			txq.push_back(net_tx_word);
		end
	end

	// Prints the counts and the verdict.
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Reads one half-word and compares it.
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		host.rd(a, d);
		`CHK(d, e)
	endtask

	// Counts interval events over a span of cycles.
	task automatic wraps(input int c, output int n);
		n = 0;
		repeat (c) begin
			@(negedge mclk);
			if (timer_wrap === 1'b1) n++;
		end
	endtask

	// Reset values, a read-only write and an unmapped read.
	task automatic t_reset();
		rc(8'h8C, 16'hFFFF);
		rc(8'h8E, 16'h0000);
		host.wr(8'h90, 16'h1234);
		rc(8'h90, 16'hFFFF);
		rc(8'h92, 16'h0000);
		rc(8'h98, 16'h0000);
		rc(8'hA0, 16'h0000);
		$display("test reset done");
	endtask

	// Preload of four gives an event every five ticks; stop restores preload.
	task automatic t_timer();
		int n;
		logic [15:0] a, b;
		host.wr(8'h8C, 16'h0004);
		host.wr(8'h8E, 16'h2000);
		wraps(160, n);
		`CHK(n >= 19 && n <= 21, 1'b1)
		host.wr(8'h8E, 16'h0000);
		rc(8'h8C, 16'hFFFF);
		host.rd(8'h90, a);
		wraps(40, n);
		`CHK(n, 0)
		host.rd(8'h90, b);
		`CHK(a, b)
		$display("test timer done");
	endtask

	// Swap pattern reverses the halves; any other value keeps them.
	task automatic t_swap();
		host.wr(8'h98, 16'hFFFF);
		host.wr(8'h9A, 16'hFFFF);
		host.wr(8'h8E, 16'h1234);
		rc(8'h8C, 16'h0000);
		rc(8'h8E, 16'h1234);
		host.wr(8'h98, 16'h0000);
		rc(8'h8C, 16'h1234);
		rc(8'h98, 16'hFFFF);
		rc(8'h9A, 16'h0000);
		host.wr(8'h98, 16'h0000);
		$display("test swap done");
	endtask

	// Two snapshots 222 cycles apart differ by about 139 ticks.
	task automatic t_free();
		logic [15:0] l1, h1, l2, h2;
		logic [31:0] d;
		host.rd(8'h9C, l1);
		host.rd(8'h9E, h1);
		repeat (200) @(posedge mclk);
		host.rd(8'h9C, l2);
		host.rd(8'h9E, h2);
		d = {h2, l2} - {h1, l1};
		`CHK(d >= 32'h0000_0082 && d <= 32'h0000_0092, 1'b1)
		$display("test free done");
	endtask

	// Network words go out and come in low word first.
	task automatic t_net();
		host.wr(8'h20, 16'hAAAA);
		host.wr(8'h22, 16'h5555);
		// The two words leave one and two cycles after the write lands.
		repeat (3) @(posedge mclk);
		#1;
		`CHK(txq.size(), 2)
		`CHK({txq[0], txq[1]}, 32'hAAAA5555)
		@(posedge mclk);
		#1;
		net_rx_word = 16'h1111;
		net_rx_valid = 1'b1;
		@(posedge mclk);
		#1;
		net_rx_word = 16'h2222;
		@(posedge mclk);
		#1;
		net_rx_valid = 1'b0;
		net_rx_word = 16'hDDDD;
		repeat (2) @(posedge mclk);
		`CHK(rx_ready, 1'b1)
		rc(8'h00, 16'h1111);
		rc(8'h02, 16'h2222);
		`CHK(rx_ready, 1'b0)
		$display("test net done");
	endtask

	// Main sequence.
	initial begin
		rstn = 1'b0;
		net_rx_word = 16'h0000;
		net_rx_valid = 1'b0;
		repeat (20) @(posedge mclk);
		#1;
		rstn = 1'b1;
		t_reset();
		t_timer();
		t_swap();
		t_free();
		t_net();
		test_done();
	end

	// Watchdog well beyond the roughly 750 cycles the tests need.
	initial begin
		repeat (6000) @(posedge mclk);
		mismatches++;
		test_done();
	end
endmodule
